// file: rtl/tcr_params.svh
// register indices, field positions and reset values of the temperature register bank
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH

// word indices; byte address is four times the index
`define TCR_IDX_EXT_TEMP_LOW      14'h2900
`define TCR_IDX_EXT_TEMP_HIGH     14'h2901
`define TCR_IDX_SOURCE_SELECT     14'h2902
`define TCR_IDX_LOW_ALARM_LOW     14'h2903
`define TCR_IDX_LOW_ALARM_HIGH    14'h2904
`define TCR_IDX_HIGH_ALARM_LOW    14'h2905
`define TCR_IDX_HIGH_ALARM_HIGH   14'h2906
`define TCR_IDX_UPDATE            14'h2910
`define TCR_IDX_ACTIVE_TEMP       14'h2911

// field positions
`define TCR_SRC_TIMEBASE_BIT      0
`define TCR_SRC_LOOP0_BIT         1
`define TCR_SRC_LOOP1_BIT         2
`define TCR_SRC_WIDTH             3
`define TCR_UPDATE_BIT            0

// reset values
`define TCR_RST_BYTE              8'h00
`define TCR_RST_SOURCE            3'h0
`define TCR_RST_TEMP              16'h0000

`endif

// file: rtl/tcr_pkg.sv
// types shared by the temperature register bank
package tcr_pkg;

  // signed q8.7 temperature: celsius times 128
  typedef struct packed {
    logic       sign;
    logic [7:0] integer_part;
    logic [6:0] fraction;
  } tcr_temp_t;

  // one apb request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } tcr_apb_req_t;

endpackage

// file: rtl/tcr_active_temp.sv
// active copy of the double-buffered external temperature
`timescale 1ns/1ps
`include "tcr_params.svh"

module tcr_active_temp #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] buffered,
  output logic      [WIDTH-1:0] active
);

  // active value moves only on the update command
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      active <= WIDTH'(`TCR_RST_TEMP);
    end else if (load) begin
      active <= buffered;
    end
  end

endmodule

// file: rtl/tcr_reg_bank.sv
// apb register bank for temperature compensation sources and alarm thresholds
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "tcr_params.svh"

// Function
// - external temperature is one signed 16-bit field, low byte then high byte, writable
// - bits 6:0 are fraction, bits 14:7 integer part of the temperature
// - external bytes are buffered; they act only after the update command
// - source register bit 2 second loop, bit 1 first loop, bit 0 timebase
// - select bit 0 uses on-chip sensor, 1 uses external temperature
module tcr_reg_bank (
  input  wire logic                      core_clk,
  input  wire logic                      reset_n,
  input  wire tcr_pkg::tcr_apb_req_t     apb_req,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire tcr_pkg::tcr_temp_t        internal_temp,
  output tcr_pkg::tcr_temp_t             active_external_temp,
  output logic [`TCR_SRC_WIDTH-1:0]      source_select,
  output tcr_pkg::tcr_temp_t [2:0]       comp_temp,
  output logic [15:0]                    low_alarm_threshold,
  output logic [15:0]                    high_alarm_threshold
);

  logic [15:0] ext_buf;
  logic [13:0] word_idx;
  logic        aligned;
  logic        setup_cyc;
  logic        access_done;
  logic        wr_done;
  logic        update_pulse;
  logic        mapped;
  logic [31:0] next_prdata;
  logic [15:0] active_raw;

  // request decode; setup cycle is the first psel cycle
  assign word_idx    = apb_req.paddr[15:2];
  assign aligned     = (apb_req.paddr[1:0] == 2'h0);
  assign setup_cyc   = apb_req.psel & ~apb_req.penable;
  assign access_done = apb_req.psel & apb_req.penable & pready;
  assign wr_done     = access_done & apb_req.pwrite & ~pslverr;
  // autoclearing update command, never stored
  assign update_pulse = wr_done & (word_idx == `TCR_IDX_UPDATE) & apb_req.pwdata[`TCR_UPDATE_BIT];

  // read mux; reserved bits read zero
  always_comb begin
    next_prdata = 32'h0000_0000;
    mapped      = aligned;
    case (word_idx)
      `TCR_IDX_EXT_TEMP_LOW:    next_prdata[7:0] = ext_buf[7:0];
      `TCR_IDX_EXT_TEMP_HIGH:   next_prdata[7:0] = ext_buf[15:8];
      `TCR_IDX_SOURCE_SELECT:   next_prdata[`TCR_SRC_WIDTH-1:0] = source_select;
      `TCR_IDX_LOW_ALARM_LOW:   next_prdata[7:0] = low_alarm_threshold[7:0];
      `TCR_IDX_LOW_ALARM_HIGH:  next_prdata[7:0] = low_alarm_threshold[15:8];
      `TCR_IDX_HIGH_ALARM_LOW:  next_prdata[7:0] = high_alarm_threshold[7:0];
      `TCR_IDX_HIGH_ALARM_HIGH: next_prdata[7:0] = high_alarm_threshold[15:8];
      `TCR_IDX_UPDATE:          next_prdata = 32'h0000_0000;
      `TCR_IDX_ACTIVE_TEMP:     next_prdata[15:0] = active_raw;
      default:                  mapped = 1'b0;
    endcase
  end

  // one wait-free access phase: answer is prepared in the setup cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup_cyc) begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
      prdata  <= (apb_req.pwrite | ~mapped) ? 32'h0000_0000 : next_prdata;
    end else begin
      pready  <= 1'b0;  // drops right after the completing edge
      pslverr <= 1'b0;
    end
  end

  // external temperature buffer bytes
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ext_buf <= `TCR_RST_TEMP;
    end else if (wr_done && word_idx == `TCR_IDX_EXT_TEMP_LOW) begin
      ext_buf[7:0] <= apb_req.pwdata[7:0];
    end else if (wr_done && word_idx == `TCR_IDX_EXT_TEMP_HIGH) begin
      ext_buf[15:8] <= apb_req.pwdata[7:0];
    end
  end

  // source selects and alarm thresholds; thresholds are only held, no alarm here
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      source_select        <= `TCR_RST_SOURCE;
      low_alarm_threshold  <= `TCR_RST_TEMP;
      high_alarm_threshold <= `TCR_RST_TEMP;
    end else if (wr_done) begin
      case (word_idx)
        `TCR_IDX_SOURCE_SELECT:   source_select <= apb_req.pwdata[`TCR_SRC_WIDTH-1:0];
        `TCR_IDX_LOW_ALARM_LOW:   low_alarm_threshold[7:0]   <= apb_req.pwdata[7:0];
        `TCR_IDX_LOW_ALARM_HIGH:  low_alarm_threshold[15:8]  <= apb_req.pwdata[7:0];
        `TCR_IDX_HIGH_ALARM_LOW:  high_alarm_threshold[7:0]  <= apb_req.pwdata[7:0];
        `TCR_IDX_HIGH_ALARM_HIGH: high_alarm_threshold[15:8] <= apb_req.pwdata[7:0];
        default: ;
      endcase
    end
  end

  // active copy moves only on update, so half-written values never reach the loops
  tcr_active_temp #(
    .WIDTH (16)
  ) u_active (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .load     (update_pulse),
    .buffered (ext_buf),
    .active   (active_raw)
  );

  // fraction in 6:0, integer in 14:7, sign on top
  assign active_external_temp = tcr_pkg::tcr_temp_t'(active_raw);

  // per-path source mux, registered so outputs leave from flops
  generate
    for (genvar i = 0; i < 3; i++) begin : g_path
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          comp_temp[i] <= tcr_pkg::tcr_temp_t'(`TCR_RST_TEMP);
        end else begin
          comp_temp[i] <= source_select[i] ? active_external_temp : internal_temp;
        end
      end

      a_path_source_pick: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(source_select[i]) && $past(reset_n)
          |-> comp_temp[i] == $past(active_raw) || !$past(reset_n, 2))
        else $error("path temperature does not follow its selected source");

      a_path_internal_pick: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(reset_n) && !$past(source_select[i]) |-> comp_temp[i] == $past(internal_temp))
        else $error("path temperature does not follow the on-chip sensor");
    end
  endgenerate

  a_ext_low_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_done && word_idx == `TCR_IDX_EXT_TEMP_LOW |=> ext_buf[7:0] == $past(apb_req.pwdata[7:0]))
    else $error("external low byte not stored on write");

  a_ext_high_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_done && word_idx == `TCR_IDX_EXT_TEMP_HIGH |=> ext_buf[15:8] == $past(apb_req.pwdata[7:0]))
    else $error("external high byte not stored on write");

  a_fixed_point_split: assert property (@(posedge core_clk) disable iff (!reset_n)
    update_pulse |=> active_external_temp.integer_part == $past(ext_buf[14:7])
                     && active_external_temp.fraction == $past(ext_buf[6:0]))
    else $error("integer or fraction part misplaced");

  a_buffer_held_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    !update_pulse ##1 $past(reset_n) |-> $stable(active_raw))
    else $error("active temperature changed without update");

  a_update_loads: assert property (@(posedge core_clk) disable iff (!reset_n)
    update_pulse |=> active_raw == $past(ext_buf))
    else $error("update did not transfer buffered temperature");

  a_source_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_done && word_idx == `TCR_IDX_SOURCE_SELECT |=> source_select == $past(apb_req.pwdata[2:0]))
    else $error("source select bits not stored");

  // reserved bits checked on their own read, so back-to-back traffic cannot trip it
  a_source_reserved: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_cyc && !apb_req.pwrite && aligned && word_idx == `TCR_IDX_SOURCE_SELECT
      |=> pready && prdata[31:3] == 29'h0)
    else $error("reserved source bits did not read zero");

  a_read_buffered: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_cyc && !apb_req.pwrite && aligned && word_idx == `TCR_IDX_EXT_TEMP_HIGH
      |=> pready && prdata[7:0] == $past(ext_buf[15:8]))
    else $error("read of external byte did not return buffer");

  a_read_low_buffered: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_cyc && !apb_req.pwrite && aligned && word_idx == `TCR_IDX_EXT_TEMP_LOW
      |=> pready && prdata[7:0] == $past(ext_buf[7:0]))
    else $error("read of external low byte did not return buffer");

  a_active_readback: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_cyc && !apb_req.pwrite && aligned && word_idx == `TCR_IDX_ACTIVE_TEMP
      |=> pready && prdata == {16'h0000, $past(active_raw)})
    else $error("read of active temperature wrong");

  // refusals are decoded apart from the mux so a broken map still shows here
  a_misaligned_refused: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_cyc && apb_req.paddr[1:0] != 2'h0
      |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("misaligned access not refused");

  a_unmapped_refused: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_cyc && (word_idx < `TCR_IDX_EXT_TEMP_LOW || word_idx > `TCR_IDX_HIGH_ALARM_HIGH)
      && word_idx != `TCR_IDX_UPDATE && word_idx != `TCR_IDX_ACTIVE_TEMP
      |=> pready && pslverr)
    else $error("unmapped access not refused");

  a_refused_write_kept: assert property (@(posedge core_clk) disable iff (!reset_n)
    access_done && apb_req.pwrite && pslverr |=> $stable(ext_buf) && $stable(source_select))
    else $error("refused write changed a register");

  a_write_reads_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_cyc && apb_req.pwrite |=> prdata == 32'h0000_0000)
    else $error("write returned nonzero read data");

  a_low_alarm_store: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_done && word_idx == `TCR_IDX_LOW_ALARM_LOW |=> low_alarm_threshold[7:0] == $past(apb_req.pwdata[7:0]))
    else $error("low alarm threshold byte not stored");

  a_high_alarm_store: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_done && word_idx == `TCR_IDX_HIGH_ALARM_HIGH |=> high_alarm_threshold[15:8] == $past(apb_req.pwdata[7:0]))
    else $error("high alarm threshold byte not stored");

  a_ready_after_setup: assert property (@(posedge core_clk) disable iff (!reset_n)
    setup_cyc |=> pready)
    else $error("pready missing after setup cycle");

  a_ready_one_cycle: assert property (@(posedge core_clk) disable iff (!reset_n)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

endmodule

// file: testbench/temperature_comp_register_bank_tb_top.sv
// self-checking bench for the temperature register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_count++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module temperature_comp_register_bank_tb_top;
  logic                     core_clk;
  logic                     reset_n;
  tcr_pkg::tcr_apb_req_t    apb_req;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  tcr_pkg::tcr_temp_t       internal_temp;
  tcr_pkg::tcr_temp_t       active_external_temp;
  logic [2:0]               source_select;
  tcr_pkg::tcr_temp_t [2:0] comp_temp;
  logic [15:0]              low_alarm_threshold;
  logic [15:0]              high_alarm_threshold;
  logic [31:0]              rd;
  logic                     slv_err;
  logic [2:0]               sels [2] = '{3'h5, 3'h2};
  int                       err_count = 0;
  int                       checked = 0;
  int                       cycles = 0;

  tcr_reg_bank u_dut (.core_clk(core_clk), .reset_n(reset_n), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internal_temp(internal_temp),
    .active_external_temp(active_external_temp), .source_select(source_select), .comp_temp(comp_temp),
    .low_alarm_threshold(low_alarm_threshold), .high_alarm_threshold(high_alarm_threshold));

  // one apb transfer; an idle cycle follows so the release never meets the next setup
  task automatic apb_xfer(input logic wr, input logic [15:0] addr, input logic [31:0] data);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    // only the hang guard ends a wait that never sees pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv_err = pslverr;
    apb_req <= '0;
    @(posedge core_clk);
  endtask

  task automatic reg_wr(input logic [15:0] addr, input logic [31:0] data, input logic ex_err);
    apb_xfer(1'b1, addr, data);
    `CHK("write error", ex_err, slv_err)
  endtask

  task automatic reg_rd(input logic [15:0] addr, input logic [31:0] ex, input logic ex_err);
    apb_xfer(1'b0, addr, 32'h0);
    `CHK("read data", ex, rd)
    `CHK("read error", ex_err, slv_err)
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // hang guard, far above the roughly 110 cycles the sequence needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      $display("mismatch timeout expected %0d seen %0d", 3000, cycles);
      give_verdict();
    end
  end

  initial begin
    reset_n = 1'b0;
    apb_req = '0;
    internal_temp = 16'h0C80;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    // the seven registers at A400 to A418 come out of reset at zero
    for (int i = 0; i < 7; i++) reg_rd(16'hA400 + 16'(4 * i), 32'h0, 1'b0);
    // minus 15.6 C encoded as celsius times 128, low byte first
    reg_wr(16'hA400, 32'h0000_0033, 1'b0);
    reg_wr(16'hA404, 32'h0000_00F8, 1'b0);
    reg_wr(16'hA408, 32'h0000_00FD, 1'b0);
    reg_wr(16'hA40C, 32'h0000_008D, 1'b0);
    reg_wr(16'hA410, 32'h0000_0011, 1'b0);
    reg_wr(16'hA418, 32'h0000_0080, 1'b0);
    reg_wr(16'hA401, 32'h0000_0055, 1'b1); // misaligned, must leave the low byte alone
    `CHK("active before update", 16'h0000, active_external_temp)
    reg_rd(16'hA400, 32'h33, 1'b0);
    reg_rd(16'hA404, 32'hF8, 1'b0);
    reg_rd(16'hA408, 32'h05, 1'b0);
    reg_rd(16'hA41C, 32'h0, 1'b1);
    reg_rd(16'hA444, 32'h0, 1'b0);
    `CHK("low threshold", 16'h118D, low_alarm_threshold)
    `CHK("high threshold", 16'h8000, high_alarm_threshold)
    reg_wr(16'hA440, 32'h1, 1'b0);
    repeat (3) @(posedge core_clk);
    `CHK("active after update", 16'hF833, active_external_temp)
    `CHK("integer part", 8'hF0, active_external_temp.integer_part)
    `CHK("fraction", 7'h33, active_external_temp.fraction)
    reg_rd(16'hA444, 32'hF833, 1'b0);
    // a new value without the command must not reach the active copy
    reg_wr(16'hA400, 32'h0000_008D, 1'b0);
    repeat (3) @(posedge core_clk);
    `CHK("active held", 16'hF833, active_external_temp)
    reg_rd(16'hA400, 32'h8D, 1'b0);
    reg_wr(16'hA400, 32'h0000_0033, 1'b0);
    // each path follows its own select bit
    foreach (sels[j]) begin
      reg_wr(16'hA408, {29'h0, sels[j]}, 1'b0);
      repeat (3) @(posedge core_clk);
      `CHK("source select", sels[j], source_select)
      for (int k = 0; k < 3; k++) `CHK("path temp", sels[j][k] ? 16'hF833 : 16'h0C80, comp_temp[k])
    end
    give_verdict();
  end
endmodule
